//--- src/hms_pkg.sv
// Constants and types for the halt-mode sleep controller
package hms_pkg;

  // Register byte offsets
  localparam logic [7:0] CLKSEL_OFS      = 8'h00;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS      = 8'h08;
  localparam logic [7:0] PORT_LATCH_OFS  = 8'h0c;

  // Clock select field positions
  localparam int unsigned CS_T4_EXT_BIT   = 0;
  localparam int unsigned CS_T8_EXT_LSB   = 1;
  localparam int unsigned CS_WATCH_SUB    = 4;
  localparam int unsigned CS_CLKOUT_SUB   = 5;
  localparam int unsigned CS_LCD_SUB      = 6;
  localparam int unsigned CS_WIDTH        = 7;

  // Status field positions
  localparam int unsigned ST_STATE_LSB    = 0;
  localparam int unsigned ST_LAST_VEC_BIT = 4;
  localparam int unsigned ST_LAST_NMI_BIT = 5;

  // Reset values
  localparam logic [6:0] CLKSEL_RESET     = 7'h00;
  localparam logic [7:0] IRQ_MASK_RESET   = 8'hff;
  localparam logic [7:0] PORT_LATCH_RESET = 8'h00;

  // Wake-up waits in CPU clocks, counted after the release cycle
  localparam logic [3:0] VEC_WAIT_CYCLES  = 4'h8;
  localparam logic [3:0] RES_WAIT_CYCLES  = 4'h2;

  localparam int unsigned NUM_IRQ         = 8;
  localparam int unsigned NUM_T8          = 3;

  typedef enum logic [3:0] {
    ST_RUN      = 4'b0001,
    ST_HALT     = 4'b0010,
    ST_WAIT_VEC = 4'b0100,
    ST_WAIT_RES = 4'b1000
  } hms_state_e;

  // Run enables for the peripherals
  typedef struct packed {
    logic           timer16a;
    logic           timer16b;
    logic [2:0]     timer8;
    logic           watch;
    logic           clkout;
    logic           lcd;
  } hms_periph_run_s;

  // Wake-up outcome towards the CPU core
  typedef struct packed {
    logic           vector;
    logic           resume;
    logic           from_nmi;
  } hms_wake_s;

endpackage : hms_pkg

//--- src/hms_halt_ctrl.sv
// Halt-mode sleep controller with APB register access
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps

// Behaviour
// [R1] Halt instruction enters halt on either clock
// [R2] Halt gates CPU clock, oscillators keep running
// [R3] Port output latches hold during halt
// [R4] Timer16a stops only halted sub, main off
// [R5] Timer16b needs ext pin when main off
// [R6] 8-bit timers need ext pin halted sub-only
// [R7] Watch timer needs main/256 when halted, main on
// [R8] Watch, clkout, LCD need sub clock sub-only
// [R9] Unmasked maskable request releases halt
// [R10] Acknowledge enabled: vector to service routine
// [R11] Acknowledge disabled: resume at next instruction
// [R12] Vectored wake waits eight or nine clocks
// [R13] Resume wake waits two or three clocks
// [R14] Non-maskable request always releases and vectors
// [R15] Only interrupt, non-maskable, reset release halt
// [R16] Reset releases halt, starts at reset vector
// [R17] Pending unmasked request cancels halt at once
module hms_halt_ctrl
  import hms_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  input  wire logic                  halt_exec,
  input  wire logic                  cpu_on_sub,
  input  wire logic                  main_osc_on,
  input  wire logic [NUM_IRQ-1:0]    irq_req,
  input  wire logic                  nmi_req,
  input  wire logic                  int_ack_en,
  input  wire logic                  timer4_ext_count_pin,
  input  wire logic [NUM_T8-1:0]     timer8_ext_count_pin,
  output logic                       cpu_clk_en,
  output logic                       halted,
  output logic                       main_osc_en,
  output logic                       sub_osc_en,
  output hms_wake_s                  wake,
  output logic                       reset_vector_go,
  output hms_periph_run_s            periph_run,
  output logic [7:0]                 port_out
);

  hms_state_e               state_reg;
  logic [3:0]               wait_cnt_reg;
  logic [CS_WIDTH-1:0]      clksel_reg;
  logic [NUM_IRQ-1:0]       irq_mask_reg;
  logic [7:0]               port_latch_reg;
  logic                     last_vec_reg;
  logic                     last_nmi_reg;
  logic                     reset_seen_reg;
  hms_wake_s                wake_reg;
  logic [31:0]              prdata_reg;
  logic                     irq_pending;
  logic                     wake_vec;
  logic                     any_wake;
  logic                     sub_only;
  logic                     apb_wr;
  logic                     apb_setup;
  logic                     addr_ok;
  logic [NUM_T8-1:0]        t8_run;

  // Wake sources: unmasked irq, non-maskable irq; reset is async
  assign irq_pending = |(irq_req & ~irq_mask_reg);                   // [R9]
  assign any_wake    = irq_pending | nmi_req;                        // [R15]
  assign wake_vec    = nmi_req | int_ack_en;                         // [R10] [R14]

  // Main state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_RUN;                                        // [R16]
      wait_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (halt_exec) begin                                       // [R1]
            if (any_wake) begin                                      // [R17]
              state_reg    <= wake_vec ? ST_WAIT_VEC : ST_WAIT_RES;
              wait_cnt_reg <= wake_vec ? VEC_WAIT_CYCLES - 4'h1
                                       : RES_WAIT_CYCLES - 4'h1;
            end else begin
              state_reg    <= ST_HALT;                               // [R1]
            end
          end
        end
        ST_HALT: begin
          if (any_wake) begin                                        // [R9]
            state_reg    <= wake_vec ? ST_WAIT_VEC : ST_WAIT_RES;    // [R10] [R11]
            wait_cnt_reg <= wake_vec ? VEC_WAIT_CYCLES - 4'h1        // [R12]
                                     : RES_WAIT_CYCLES - 4'h1;       // [R13]
          end
        end
        ST_WAIT_VEC, ST_WAIT_RES: begin
          if (wait_cnt_reg == 4'h0) begin
            state_reg <= ST_RUN;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;                     // [R12] [R13]
          end
        end
      endcase
    end
  end

  // Wake outcome pulse in the first running cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg     <= '0;
      last_vec_reg <= 1'b0;
      last_nmi_reg <= 1'b0;
    end else begin
      wake_reg <= '0;
      if ((state_reg == ST_RUN && halt_exec && any_wake) ||
          (state_reg == ST_HALT && any_wake)) begin
        last_vec_reg <= wake_vec;
        last_nmi_reg <= nmi_req;                                     // [R14]
      end
      if (state_reg == ST_WAIT_VEC && wait_cnt_reg == 4'h0) begin
        wake_reg.vector   <= 1'b1;                                   // [R10]
        wake_reg.from_nmi <= last_nmi_reg;
      end
      if (state_reg == ST_WAIT_RES && wait_cnt_reg == 4'h0) begin
        wake_reg.resume   <= 1'b1;                                   // [R11]
      end
    end
  end

  // Reset-vector start: high during reset and for the first cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_seen_reg <= 1'b0;
    end else begin
      reset_seen_reg <= 1'b1;
    end
  end

  assign reset_vector_go = ~reset_seen_reg;                          // [R16]
  assign wake            = wake_reg;
  assign cpu_clk_en      = (state_reg == ST_RUN);                    // [R2]
  assign halted          = (state_reg == ST_HALT);
  assign main_osc_en     = 1'b1;                                     // [R2]
  assign sub_osc_en      = 1'b1;                                     // [R2]

  // Peripheral run enables
  assign sub_only = ~cpu_clk_en & cpu_on_sub & ~main_osc_on;

  always_comb begin
    periph_run.timer16a = ~sub_only;                                 // [R4]
    periph_run.timer16b = main_osc_on |
                          clksel_reg[CS_T4_EXT_BIT];                 // [R5]
    periph_run.timer8   = t8_run;                                    // [R6]
    periph_run.watch    = main_osc_on
                          ? (cpu_clk_en | ~clksel_reg[CS_WATCH_SUB]) // [R7]
                          : clksel_reg[CS_WATCH_SUB];                // [R8]
    periph_run.clkout   = ~sub_only | clksel_reg[CS_CLKOUT_SUB];     // [R8]
    periph_run.lcd      = ~sub_only | clksel_reg[CS_LCD_SUB];        // [R8]
  end

  for (genvar i = 0; i < NUM_T8; i++) begin : g_t8
    assign t8_run[i] = ~sub_only |
                       clksel_reg[CS_T8_EXT_LSB + i];                // [R6]
  end

  // APB slave
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & addr_ok;
  assign pready    = 1'b1;
  assign addr_ok   = (paddr == CLKSEL_OFS) || (paddr == IRQ_MASK_OFS) ||
                     (paddr == STATUS_OFS) || (paddr == PORT_LATCH_OFS);
  assign pslverr   = psel & penable & ~addr_ok;
  assign prdata    = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel_reg   <= CLKSEL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (apb_wr) begin
      if (paddr == CLKSEL_OFS) begin
        clksel_reg <= pwdata[CS_WIDTH-1:0];
      end
      if (paddr == IRQ_MASK_OFS) begin
        irq_mask_reg <= pwdata[NUM_IRQ-1:0];
      end
    end
  end

  // Port latch: writes only while the CPU runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch_reg <= PORT_LATCH_RESET;
    end else if (apb_wr && paddr == PORT_LATCH_OFS && cpu_clk_en) begin
      port_latch_reg <= pwdata[7:0];                                 // [R3]
    end
  end

  assign port_out = port_latch_reg;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= 32'h0000_0000;
      unique case (paddr)
        CLKSEL_OFS:     prdata_reg[CS_WIDTH-1:0] <= clksel_reg;
        IRQ_MASK_OFS:   prdata_reg[NUM_IRQ-1:0]  <= irq_mask_reg;
        STATUS_OFS: begin
          prdata_reg[ST_STATE_LSB +: 4]   <= state_reg;
          prdata_reg[ST_LAST_VEC_BIT]     <= last_vec_reg;
          prdata_reg[ST_LAST_NMI_BIT]     <= last_nmi_reg;
        end
        PORT_LATCH_OFS: prdata_reg[7:0]          <= port_latch_reg;
        default:        prdata_reg               <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  sequence s_rel_vec;
    (state_reg == ST_WAIT_VEC)[*8] ##1 (wake.vector && cpu_clk_en);
  endsequence

  sequence s_rel_res;
    (state_reg == ST_WAIT_RES)[*2] ##1 (wake.resume && cpu_clk_en);
  endsequence

  property p_halt_entry;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_RUN && halt_exec && !any_wake)
      |=> (halted && !cpu_clk_en && main_osc_en && sub_osc_en);
  endproperty
  a_halt_entry: assert property (p_halt_entry) // [R1] [R2]
    else $error("halt not entered");

  property p_port_hold;
    @(posedge pclk) disable iff (!presetn)
    (!cpu_clk_en && $past(!cpu_clk_en)) |-> $stable(port_out);
  endproperty
  a_port_hold: assert property (p_port_hold) // [R3]
    else $error("port latch changed while halted");

  property p_t16a;
    @(posedge pclk) disable iff (!presetn)
    periph_run.timer16a == !(!cpu_clk_en && cpu_on_sub && !main_osc_on);
  endproperty
  a_t16a: assert property (p_t16a) // [R4]
    else $error("timer16a run enable wrong");

  property p_t16b;
    @(posedge pclk) disable iff (!presetn)
    !main_osc_on |-> (periph_run.timer16b == clksel_reg[CS_T4_EXT_BIT]);
  endproperty
  a_t16b: assert property (p_t16b) // [R5]
    else $error("timer16b run enable wrong");

  property p_t8;
    @(posedge pclk) disable iff (!presetn)
    (halted && cpu_on_sub && !main_osc_on)
      |-> (periph_run.timer8 == clksel_reg[CS_T8_EXT_LSB +: 3]);
  endproperty
  a_t8: assert property (p_t8) // [R6]
    else $error("timer8 run enable wrong");

  property p_watch_main;
    @(posedge pclk) disable iff (!presetn)
    (halted && main_osc_on)
      |-> (periph_run.watch == !clksel_reg[CS_WATCH_SUB]);
  endproperty
  a_watch_main: assert property (p_watch_main) // [R7]
    else $error("watch timer enable wrong");

  property p_wake_vec;
    @(posedge pclk) disable iff (!presetn)
    (halted && irq_pending && int_ack_en && !nmi_req) |=> s_rel_vec;
  endproperty
  a_wake_vec: assert property (p_wake_vec) // [R9] [R10] [R12]
    else $error("vectored wake timing wrong");

  property p_wake_res;
    @(posedge pclk) disable iff (!presetn)
    (halted && irq_pending && !int_ack_en && !nmi_req) |=> s_rel_res;
  endproperty
  a_wake_res: assert property (p_wake_res) // [R11] [R13]
    else $error("resume wake timing wrong");

  property p_nmi;
    @(posedge pclk) disable iff (!presetn)
    (halted && nmi_req) |=> s_rel_vec ##0 wake.from_nmi;
  endproperty
  a_nmi: assert property (p_nmi) // [R14]
    else $error("nmi wake not vectored");

  property p_stay;
    @(posedge pclk) disable iff (!presetn)
    (halted && !irq_pending && !nmi_req) |=> halted;
  endproperty
  a_stay: assert property (p_stay) // [R15]
    else $error("halt released without source");

  property p_pending;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_RUN && halt_exec && any_wake) |=> !halted;
  endproperty
  a_pending: assert property (p_pending) // [R17]
    else $error("halt kept despite pending request");

  property p_sub_periph;
    @(posedge pclk) disable iff (!presetn)
    (!cpu_clk_en && cpu_on_sub && !main_osc_on)
      |-> (periph_run.watch  == clksel_reg[CS_WATCH_SUB] &&
           periph_run.clkout == clksel_reg[CS_CLKOUT_SUB] &&
           periph_run.lcd    == clksel_reg[CS_LCD_SUB]);
  endproperty
  a_sub_periph: assert property (p_sub_periph) // [R8]
    else $error("sub-only peripheral enable wrong");

  property p_rst_vec;
    @(posedge pclk) disable iff (!presetn)
    (reset_vector_go && presetn)
      |=> (!reset_vector_go && cpu_clk_en && !halted);
  endproperty
  a_rst_vec: assert property (p_rst_vec) // [R16]
    else $error("reset vector start wrong");

  property p_wake_once;
    @(posedge pclk) disable iff (!presetn)
    (wake != 3'b000) |=> (wake == 3'b000);
  endproperty
  a_wake_once: assert property (p_wake_once) // [R10] [R11]
    else $error("wake pulse too long");

  property p_port_refuse;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !cpu_clk_en) |=> $stable(port_out);
  endproperty
  a_port_refuse: assert property (p_port_refuse) // [R3]
    else $error("port latch written while halted");

endmodule : hms_halt_ctrl

//--- testbench/hms_cpu_model.sv
// CPU core and interrupt request controller model
`timescale 1ns/10ps
module hms_cpu_model
  import hms_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               go_halt,
  input  wire logic [NUM_IRQ-1:0] set_irq,
  input  wire logic               set_nmi,
  input  wire logic               cpu_clk_en,
  input  wire hms_wake_s          wake,
  output logic                    halt_exec,
  output logic [NUM_IRQ-1:0]      irq_req,
  output logic                    nmi_req
);
  // Halt instruction only while clocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_exec <= 1'b0;
    end else begin
      halt_exec <= go_halt & cpu_clk_en;
    end
  end
  // Requests held until vectored service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= '0;
      nmi_req <= 1'b0;
    end else if (wake.vector) begin
      irq_req <= '0;
      nmi_req <= 1'b0;
    end else begin
      irq_req <= irq_req | set_irq;
      nmi_req <= nmi_req | set_nmi;
    end
  end
endmodule : hms_cpu_model

//--- testbench/hms_halt_ctrl_tb.sv
// Self-checking bench for the halt-mode sleep controller
`timescale 1ns/10ps
module hms_halt_ctrl_tb
  import hms_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, irq_req, set_irq, port_out;
  logic [31:0]     pwdata, prdata;
  logic            halt_exec, nmi_req, cpu_clk_en, halted, go_halt, set_nmi;
  logic            cpu_on_sub, main_osc_on, int_ack_en, t4_pin;
  logic            main_osc_en, sub_osc_en, reset_vector_go;
  logic [2:0]      t8_pin;
  hms_wake_s       wake;
  hms_periph_run_s periph_run;
  int              fails, cmp_count;

  hms_halt_ctrl i_hms_halt_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .halt_exec(halt_exec), .cpu_on_sub(cpu_on_sub),
    .main_osc_on(main_osc_on), .irq_req(irq_req), .nmi_req(nmi_req),
    .int_ack_en(int_ack_en), .timer4_ext_count_pin(t4_pin),
    .timer8_ext_count_pin(t8_pin), .cpu_clk_en(cpu_clk_en),
    .halted(halted), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .wake(wake), .reset_vector_go(reset_vector_go),
    .periph_run(periph_run), .port_out(port_out));
  hms_cpu_model i_hms_cpu_model (.pclk(pclk), .presetn(presetn),
    .go_halt(go_halt), .set_irq(set_irq), .set_nmi(set_nmi),
    .cpu_clk_en(cpu_clk_en), .wake(wake), .halt_exec(halt_exec),
    .irq_req(irq_req), .nmi_req(nmi_req));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("counts: %0d compared, %0d bad", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fails++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    @(negedge pclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rd

  task automatic do_halt;
    @(posedge pclk);
    go_halt <= 1'b1;
    @(posedge pclk);
    go_halt <= 1'b0;
    repeat (3) @(negedge pclk);
  endtask : do_halt

  task automatic req(input logic [7:0] m, input logic n);
    @(posedge pclk);
    set_irq <= m;
    set_nmi <= n;
    @(posedge pclk);
    set_irq <= 8'h00;
    set_nmi <= 1'b0;
  endtask : req

  task automatic wake_chk(input logic [2:0] xw, input int xn);
    int n;
    n = 0;
    while (halted !== 1'b0 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 50) begin
      fails++;
      end_sim();
    end
    n = 0;
    while (wake === 3'b000 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 50) begin
      fails++;
      end_sim();
    end
    if (xn >= 0) chk("wake_wait", xn, n);
    chk("wake", {29'h0, xw}, {29'h0, wake});
    chk("cpu_clk_en", 1, {31'h0, cpu_clk_en});
  endtask : wake_chk

  task automatic t_regs;
    rd(CLKSEL_OFS, 32'h0, 1'b0);
    rd(IRQ_MASK_OFS, 32'hff, 1'b0);
    rd(STATUS_OFS, 32'h1, 1'b0);
    wr(STATUS_OFS, 32'hff);
    rd(STATUS_OFS, 32'h1, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(PORT_LATCH_OFS, 32'h5a);
    rd(PORT_LATCH_OFS, 32'h5a, 1'b0);
    $display("done regs");
  endtask : t_regs

  task automatic t_vec;
    int_ack_en <= 1'b1;
    wr(IRQ_MASK_OFS, 32'hfe);
    do_halt();
    chk("halted", 1, {31'h0, halted});
    chk("clk_osc", 3'b011, {cpu_clk_en, main_osc_en, sub_osc_en});
    wr(PORT_LATCH_OFS, 32'h00);
    chk("port_out", 8'h5a, port_out);
    chk("run_main", 7'h7f, periph_run[7:1]);
    wr(CLKSEL_OFS, 32'h10);
    chk("watch_sub", 0, {31'h0, periph_run.watch});
    wr(CLKSEL_OFS, 32'h0);
    req(8'h02, 1'b0);
    repeat (4) @(negedge pclk);
    chk("masked", 1, {31'h0, halted});
    req(8'h01, 1'b0);
    wake_chk(3'b100, 8);
    $display("done vectored");
  endtask : t_vec

  task automatic t_res;
    @(posedge pclk);
    int_ack_en <= 1'b0;
    cpu_on_sub <= 1'b1;
    main_osc_on <= 1'b0;
    do_halt();
    chk("halted_sub", 1, {31'h0, halted});
    chk("run_sub0", 8'h00, periph_run);
    wr(CLKSEL_OFS, 32'h7f);
    chk("run_sub1", 8'h7f, periph_run);
    req(8'h01, 1'b0);
    wake_chk(3'b010, 2);
    do_halt();
    chk("no_halt", 0, {31'h0, halted});
    wake_chk(3'b010, -1);
    $display("done resume");
  endtask : t_res

  task automatic t_nmi;
    wr(IRQ_MASK_OFS, 32'hff);
    do_halt();
    repeat (4) @(negedge pclk);
    chk("halt_hold", 1, {31'h0, halted});
    req(8'h00, 1'b1);
    wake_chk(3'b101, 8);
    $display("done nmi");
  endtask : t_nmi

  task automatic t_rst;
    do_halt();
    chk("halted_pre", 1, {31'h0, halted});
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("rst_out", 3'b011, {halted, reset_vector_go, cpu_clk_en});
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("rvg_on", 1, {31'h0, reset_vector_go});
    @(negedge pclk);
    chk("rvg_off", 0, {31'h0, reset_vector_go});
    rd(IRQ_MASK_OFS, 32'hff, 1'b0);
    rd(CLKSEL_OFS, 32'h0, 1'b0);
    rd(PORT_LATCH_OFS, 32'h0, 1'b0);
    $display("done reset");
  endtask : t_rst

  initial begin
    {presetn, psel, penable, pwrite, go_halt, set_nmi} = 6'h0;
    {cpu_on_sub, int_ack_en, t4_pin, t8_pin} = 6'h0;
    {paddr, set_irq, pwdata} = 48'h0;
    main_osc_on = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_vec();
    t_res();
    t_nmi();
    t_rst();
    end_sim();
  end
endmodule : hms_halt_ctrl_tb
